// ===== include/crbt_params.svh
// constants for the capture/reload/baud timer block
// assumes a single 200 MHz clock; included by bare name from the core files
`ifndef CRBT_PARAMS_SVH
`define CRBT_PARAMS_SVH

// register bus geometry
`define CRBT_AW 5
`define CRBT_DW 8
`define CRBT_NUM_TIMERS 3

// per-timer byte offsets, timer index sits in address bits 4:3
`define CRBT_OFF_CNT_LO 3'h0
`define CRBT_OFF_CNT_HI 3'h1
`define CRBT_OFF_HOLD_LO 3'h2
`define CRBT_OFF_HOLD_HI 3'h3
`define CRBT_OFF_CTL 3'h4
// system configuration register address
`define CRBT_ADDR_SYSCFG 5'h18

// timer control register bit positions
`define CRBT_CTL_OVF 7
`define CRBT_CTL_EXT 6
`define CRBT_CTL_RXB 5
`define CRBT_CTL_TXB 4
`define CRBT_CTL_EXEN 3
`define CRBT_CTL_RUN 2
`define CRBT_CTL_SRC 1
`define CRBT_CTL_CPRL 0

// system configuration bit positions
`define CRBT_SYS_T0_SLOW 0
`define CRBT_SYS_T1_SLOW 1
`define CRBT_SYS_EDGE_RISE 2
`define CRBT_SYS_EDGE_FALL 3
`define CRBT_SYS_T2_PCLK 4

// reset values
`define CRBT_CTL_RST 8'h00
`define CRBT_SYSCFG_RST 8'h08
`define CRBT_BYTE_ZERO 8'h00

// counter limits
`define CRBT_COUNT_MAX 16'hffff
`define CRBT_COUNT_ONE 16'h0001

// prescaler terminal counts: crystal /2, crystal /32, peripheral clock /4
`define CRBT_XTAL_FAST_LAST 5'h01
`define CRBT_XTAL_SLOW_LAST 5'h1f
`define CRBT_PCLK_LAST 3'h7
`define CRBT_PRE_ONE 5'h01
`define CRBT_PCLK_ONE 3'h1

// uart sixteen-fold sub-divider
`define CRBT_BAUD_SUB_LAST 4'hf
`define CRBT_BAUD_SUB_ONE 4'h1

`endif

// ===== include/crbt_pkg.sv
// types shared by the timer block files
// no constants here; numbers live in crbt_params.svh
package crbt_pkg;

   // operating mode, gray coded along off -> reload -> capture -> baud
   typedef enum logic [1:0] {
      CRBT_MODE_OFF = 2'h0,
      CRBT_MODE_RELOAD = 2'h1,
      CRBT_MODE_CAPTURE = 2'h3,
      CRBT_MODE_BAUD = 2'h2
   } crbt_mode_e;

   typedef logic [15:0] crbt_count_t;

endpackage

// ===== core/crbt_prescaler.sv
// prescaler producing the internal count enables
// assumes clk is the crystal clock; peripheral clock is crystal /2 here
`timescale 1ns/10ps
`default_nettype none
`include "crbt_params.svh"

module crbt_prescaler (
   input wire logic clk,
   input wire logic rst,
   output logic tickXtalFast,
   output logic tickXtalSlow,
   output logic tickPclk
);

   logic [4:0] xtalCnt_q, xtalCnt_d; // free running crystal divider
   logic [2:0] pclkCnt_q, pclkCnt_d; // peripheral clock /4 divider
   logic fast_d, slow_d, pclk_d;

   // next divider values and terminal-count pulses
   always_comb begin
      xtalCnt_d = xtalCnt_q + `CRBT_PRE_ONE;
      pclkCnt_d = pclkCnt_q + `CRBT_PCLK_ONE;
      // lowest divider bit toggles every cycle, so it marks every other cycle
      fast_d = xtalCnt_q[0];
      slow_d = (xtalCnt_q == `CRBT_XTAL_SLOW_LAST);
      pclk_d = (pclkCnt_q == `CRBT_PCLK_LAST);
   end

   // pulses registered so every consumer sees a clean one-cycle enable
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         xtalCnt_q <= 5'h00;
         pclkCnt_q <= 3'h0;
         tickXtalFast <= 1'b0;
         tickXtalSlow <= 1'b0;
         tickPclk <= 1'b0;
      end else begin
         xtalCnt_q <= xtalCnt_d;
         pclkCnt_q <= pclkCnt_d;
         tickXtalFast <= fast_d;
         tickXtalSlow <= slow_d;
         tickPclk <= pclk_d;
      end
   end

endmodule
`default_nettype wire

// ===== core/crbt_pin_sync.sv
// event pin synchroniser with selectable edge detection
// assumes the pin is asynchronous to clk
`timescale 1ns/10ps
`default_nettype none
`include "crbt_params.svh"

module crbt_pin_sync (
   input wire logic clk,
   input wire logic rst,
   input wire logic pinIn,
   input wire logic riseEn,
   input wire logic fallEn,
   output logic validEdge
);

   logic s1_q, s2_q, s3_q; // three-stage synchroniser
   logic level_q, level_d; // filtered level, moves only when stages 2 and 3 agree
   logic edge_d;

   // filter and edge decision; stage 1 is read by stage 2 only
   always_comb begin
      level_d = (s2_q == s3_q) ? s3_q : level_q;
      edge_d = (riseEn && level_d && !level_q) || (fallEn && !level_d && level_q);
   end

   // pin idles high, so reset to one to avoid a false falling edge
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         s1_q <= 1'b1;
         s2_q <= 1'b1;
         s3_q <= 1'b1;
         level_q <= 1'b1;
         validEdge <= 1'b0;
      end else begin
         s1_q <= pinIn;
         s2_q <= s1_q;
         s3_q <= s2_q;
         level_q <= level_d;
         validEdge <= edge_d;
      end
   end

endmodule
`default_nettype wire

// ===== core/crbt_timers.sv
// three 16-bit capture / auto-reload / baud timers with a byte register port
// assumes one clock, asynchronous reset, and a uart that takes the tick outputs
//
// Contract
// [RULE1] three independent 16-bit counters, two bytes each
// [RULE2] each timer owns a 16-bit hold register pair
// [RULE3] count source internal clock or external transitions
// [RULE4] internal rates crystal /2, /32, or peripheral /4
// [RULE5] timer 0 edge select: none, rise, fall, both
// [RULE6] timers 1 and 2 count falling edges only
// [RULE7] capture mode overflow sets overflow flag
// [RULE8] capture trigger copies counter into hold bytes
// [RULE9] capture trigger sets external flag
// [RULE10] reload mode overflow sets flag and reloads
// [RULE11] reload trigger reloads counter and sets flag
// [RULE12] baud selects make overflows clock the uart
// [RULE13] baud mode rollover reloads from hold pair
// [RULE14] baud rate is rate over sixteen periods
// [RULE15] baud mode overflow never sets overflow flag
// [RULE16] baud mode trigger sets external flag
// [RULE17] run bit counts when one, stops otherwise
// [RULE18] baud select forces reload, else select chooses
// [RULE19] hardware only sets flags, software clears them
// [RULE20] source select zero timer, one event counter
// [RULE21] overflow is wrap to zero, one pulse
//
// Local design decisions: the register offsets and the address-and-strobe port.
`timescale 1ns/10ps
`default_nettype none
`include "crbt_params.svh"

module crbt_timers (
   input wire logic clk,
   input wire logic rst,
   input wire logic [`CRBT_AW-1:0] addr,
   input wire logic [`CRBT_DW-1:0] wdata,
   input wire logic wrStb,
   input wire logic rdStb,
   output logic [`CRBT_DW-1:0] rdata,
   input wire logic [`CRBT_NUM_TIMERS-1:0] eventInputPin,
   output logic [`CRBT_NUM_TIMERS-1:0] overflowFlag,
   output logic [`CRBT_NUM_TIMERS-1:0] externalFlag,
   output logic [`CRBT_NUM_TIMERS-1:0] overflowPulse,
   output logic rxBaudTick,
   output logic txBaudTick,
   output logic rxBitTick,
   output logic txBitTick
);

   // register state
   crbt_pkg::crbt_count_t count_q [`CRBT_NUM_TIMERS]; // count_high_byte:count_low_byte
   crbt_pkg::crbt_count_t count_d [`CRBT_NUM_TIMERS];
   crbt_pkg::crbt_count_t hold_q [`CRBT_NUM_TIMERS]; // hold_high_byte:hold_low_byte
   crbt_pkg::crbt_count_t hold_d [`CRBT_NUM_TIMERS];
   logic [7:0] ctl_q [`CRBT_NUM_TIMERS]; // timer_control_reg per timer
   logic [7:0] ctl_d [`CRBT_NUM_TIMERS];
   logic [7:0] sysCfg_q, sysCfg_d; // system_config_two
   logic [`CRBT_DW-1:0] rdata_d;
   logic [`CRBT_NUM_TIMERS-1:0] ovfPulse_d;
   logic rxTick_d, txTick_d, rxBit_d, txBit_d;
   logic [3:0] rxSub_q, rxSub_d, txSub_q, txSub_d; // uart sixteen-fold dividers

   // per-timer decode results, also read by the checks
   crbt_pkg::crbt_mode_e mode [`CRBT_NUM_TIMERS];
   logic [`CRBT_NUM_TIMERS-1:0] intTick; // selected internal rate
   logic [`CRBT_NUM_TIMERS-1:0] extEdge; // qualified pin transition
   logic [`CRBT_NUM_TIMERS-1:0] cntTick; // counting enable
   logic [`CRBT_NUM_TIMERS-1:0] wrap; // counter wraps this cycle
   logic [`CRBT_NUM_TIMERS-1:0] trig; // external capture/reload trigger
   logic [`CRBT_NUM_TIMERS-1:0] swCntWr, swHoldWr, swCtlWr;
   logic [`CRBT_NUM_TIMERS-1:0] edgeRise, edgeFall;
   logic tickFast, tickSlow, tickPclk;

   // address match of one timer register
   function automatic logic hitReg(input logic [`CRBT_AW-1:0] a, input int t,
                                   input logic [2:0] off);
      hitReg = (a[4:3] == t[1:0]) && (a[2:0] == off);
   endfunction

   // mode from the control byte; baud select overrides capture/reload select
   function automatic crbt_pkg::crbt_mode_e modeOf(input logic [7:0] c);
      if (!c[`CRBT_CTL_RUN])
         modeOf = crbt_pkg::CRBT_MODE_OFF; // [RULE17]
      else if (c[`CRBT_CTL_RXB] || c[`CRBT_CTL_TXB])
         modeOf = crbt_pkg::CRBT_MODE_BAUD; // [RULE18] [RULE12]
      else if (c[`CRBT_CTL_CPRL])
         modeOf = crbt_pkg::CRBT_MODE_CAPTURE; // [RULE18]
      else
         modeOf = crbt_pkg::CRBT_MODE_RELOAD;
   endfunction

   // shared rate enables
   crbt_prescaler prescale (
      .clk(clk),
      .rst(rst),
      .tickXtalFast(tickFast),
      .tickXtalSlow(tickSlow),
      .tickPclk(tickPclk)
   );

   // edge qualifiers: timer 0 programmable, the others falling only
   always_comb begin
      edgeRise = {1'b0, 1'b0, sysCfg_q[`CRBT_SYS_EDGE_RISE]}; // [RULE5] [RULE6]
      edgeFall = {1'b1, 1'b1, sysCfg_q[`CRBT_SYS_EDGE_FALL]}; // [RULE5] [RULE6]
   end

   // one synchroniser per event pin
   genvar g;
   generate
      for (g = 0; g < `CRBT_NUM_TIMERS; g++) begin : gSync
         crbt_pin_sync sync (
            .clk(clk),
            .rst(rst),
            .pinIn(eventInputPin[g]),
            .riseEn(edgeRise[g]),
            .fallEn(edgeFall[g]),
            .validEdge(extEdge[g])
         );
      end
   endgenerate

   // decode: rates, tick, wrap, trigger and software write hits
   always_comb begin
      intTick[0] = sysCfg_q[`CRBT_SYS_T0_SLOW] ? tickSlow : tickFast; // [RULE4]
      intTick[1] = sysCfg_q[`CRBT_SYS_T1_SLOW] ? tickSlow : tickFast; // [RULE4]
      intTick[2] = sysCfg_q[`CRBT_SYS_T2_PCLK] ? tickPclk : tickFast; // [RULE4]
      for (int i = 0; i < `CRBT_NUM_TIMERS; i++) begin
         mode[i] = modeOf(ctl_q[i]);
         // the same pin both counts and triggers; that is the only input it has
         cntTick[i] = ctl_q[i][`CRBT_CTL_SRC] ? extEdge[i] : intTick[i]; // [RULE3] [RULE20]
         cntTick[i] = cntTick[i] && ctl_q[i][`CRBT_CTL_RUN]; // [RULE17]
         wrap[i] = cntTick[i] && (count_q[i] == `CRBT_COUNT_MAX); // [RULE21]
         trig[i] = ctl_q[i][`CRBT_CTL_RUN] && ctl_q[i][`CRBT_CTL_EXEN] && extEdge[i];
         swCntWr[i] = wrStb && (hitReg(addr, i, `CRBT_OFF_CNT_LO) ||
                                hitReg(addr, i, `CRBT_OFF_CNT_HI));
         swHoldWr[i] = wrStb && (hitReg(addr, i, `CRBT_OFF_HOLD_LO) ||
                                 hitReg(addr, i, `CRBT_OFF_HOLD_HI));
         swCtlWr[i] = wrStb && hitReg(addr, i, `CRBT_OFF_CTL);
      end
   end

   // timer next state: counting, reload, capture, flags and software writes
   always_comb begin
      for (int i = 0; i < `CRBT_NUM_TIMERS; i++) begin
         count_d[i] = count_q[i];
         hold_d[i] = hold_q[i];
         ctl_d[i] = ctl_q[i];
         ovfPulse_d[i] = wrap[i]; // [RULE21]
         if (cntTick[i])
            count_d[i] = count_q[i] + `CRBT_COUNT_ONE; // [RULE1]
         // capture mode lets the counter roll on to zero
         if (wrap[i] && mode[i] != crbt_pkg::CRBT_MODE_CAPTURE)
            count_d[i] = hold_q[i]; // [RULE10] [RULE13]
         if (trig[i] && mode[i] == crbt_pkg::CRBT_MODE_RELOAD)
            count_d[i] = hold_q[i]; // [RULE11]
         if (trig[i] && mode[i] == crbt_pkg::CRBT_MODE_CAPTURE)
            hold_d[i] = count_q[i]; // [RULE8] [RULE2]
         // software byte writes take precedence over hardware data updates
         if (swCntWr[i] && addr[0])
            count_d[i][15:8] = wdata;
         else if (swCntWr[i])
            count_d[i][7:0] = wdata;
         if (swHoldWr[i] && addr[0])
            hold_d[i][15:8] = wdata;
         else if (swHoldWr[i])
            hold_d[i][7:0] = wdata;
         if (swCtlWr[i])
            ctl_d[i] = wdata; // writing zero to a flag clears it
         // hardware sets after the write so a same-cycle event is never lost
         if (wrap[i] && mode[i] != crbt_pkg::CRBT_MODE_BAUD)
            ctl_d[i][`CRBT_CTL_OVF] = 1'b1; // [RULE7] [RULE10] [RULE15] [RULE19]
         if (trig[i])
            ctl_d[i][`CRBT_CTL_EXT] = 1'b1; // [RULE9] [RULE11] [RULE16] [RULE19]
      end
   end

   // uart clocking: overflow pulses of baud timers, then divide by sixteen
   always_comb begin
      rxTick_d = 1'b0;
      txTick_d = 1'b0;
      for (int i = 0; i < `CRBT_NUM_TIMERS; i++) begin
         // two timers on one direction add pulses; software must avoid that
         rxTick_d = rxTick_d || (wrap[i] && ctl_q[i][`CRBT_CTL_RXB]); // [RULE12]
         txTick_d = txTick_d || (wrap[i] && ctl_q[i][`CRBT_CTL_TXB]); // [RULE12]
      end
      rxSub_d = rxTick_d ? rxSub_q + `CRBT_BAUD_SUB_ONE : rxSub_q;
      txSub_d = txTick_d ? txSub_q + `CRBT_BAUD_SUB_ONE : txSub_q;
      rxBit_d = rxTick_d && (rxSub_q == `CRBT_BAUD_SUB_LAST); // [RULE14]
      txBit_d = txTick_d && (txSub_q == `CRBT_BAUD_SUB_LAST); // [RULE14]
   end

   // system config write and registered read mux; unmapped reads give zero
   always_comb begin
      sysCfg_d = sysCfg_q;
      if (wrStb && addr == `CRBT_ADDR_SYSCFG)
         sysCfg_d = wdata;
      rdata_d = `CRBT_BYTE_ZERO;
      if (rdStb && addr == `CRBT_ADDR_SYSCFG)
         rdata_d = sysCfg_q;
      else if (rdStb && addr[4:3] != 2'h3) begin
         unique case (addr[2:0])
            `CRBT_OFF_CNT_LO: rdata_d = count_q[addr[4:3]][7:0];
            `CRBT_OFF_CNT_HI: rdata_d = count_q[addr[4:3]][15:8];
            `CRBT_OFF_HOLD_LO: rdata_d = hold_q[addr[4:3]][7:0];
            `CRBT_OFF_HOLD_HI: rdata_d = hold_q[addr[4:3]][15:8];
            `CRBT_OFF_CTL: rdata_d = ctl_q[addr[4:3]];
            default: rdata_d = `CRBT_BYTE_ZERO;
         endcase
      end
   end

   // state registers
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         for (int i = 0; i < `CRBT_NUM_TIMERS; i++) begin
            count_q[i] <= 16'h0000;
            hold_q[i] <= 16'h0000;
            ctl_q[i] <= `CRBT_CTL_RST;
         end
         sysCfg_q <= `CRBT_SYSCFG_RST;
         rdata <= `CRBT_BYTE_ZERO;
         overflowPulse <= 3'h0;
         rxBaudTick <= 1'b0;
         txBaudTick <= 1'b0;
         rxBitTick <= 1'b0;
         txBitTick <= 1'b0;
         rxSub_q <= 4'h0;
         txSub_q <= 4'h0;
      end else begin
         count_q <= count_d;
         hold_q <= hold_d;
         ctl_q <= ctl_d;
         sysCfg_q <= sysCfg_d;
         rdata <= rdata_d;
         overflowPulse <= ovfPulse_d;
         rxBaudTick <= rxTick_d;
         txBaudTick <= txTick_d;
         rxBitTick <= rxBit_d;
         txBitTick <= txBit_d;
         rxSub_q <= rxSub_d;
         txSub_q <= txSub_d;
      end
   end

   // flags leave straight from the control flops
   always_comb begin
      for (int i = 0; i < `CRBT_NUM_TIMERS; i++) begin
         overflowFlag[i] = ctl_q[i][`CRBT_CTL_OVF];
         externalFlag[i] = ctl_q[i][`CRBT_CTL_EXT];
      end
   end

   // per-timer checks
   generate
      for (g = 0; g < `CRBT_NUM_TIMERS; g++) begin : gChk
         count_step_a: assert property (@(posedge clk) disable iff (rst) // [RULE1]
            (cntTick[g] && !wrap[g] && !trig[g] && !swCntWr[g])
            |=> count_q[g] == $past(count_q[g]) + `CRBT_COUNT_ONE)
            else $error("counter did not step by one");
         capture_ovf_a: assert property (@(posedge clk) disable iff (rst) // [RULE7]
            (wrap[g] && mode[g] == crbt_pkg::CRBT_MODE_CAPTURE && !swCntWr[g])
            |=> ctl_q[g][`CRBT_CTL_OVF] && count_q[g] == 16'h0000)
            else $error("capture overflow flag or wrap wrong");
         capture_copy_a: assert property (@(posedge clk) disable iff (rst) // [RULE8]
            (trig[g] && mode[g] == crbt_pkg::CRBT_MODE_CAPTURE && !swHoldWr[g])
            |=> hold_q[g] == $past(count_q[g]))
            else $error("capture did not copy counter");
         ext_flag_a: assert property (@(posedge clk) disable iff (rst) // [RULE9]
            trig[g] |=> ctl_q[g][`CRBT_CTL_EXT])
            else $error("external flag not set");
         reload_load_a: assert property (@(posedge clk) disable iff (rst) // [RULE10]
            (wrap[g] && mode[g] == crbt_pkg::CRBT_MODE_RELOAD && !swCntWr[g])
            |=> count_q[g] == $past(hold_q[g]) && ctl_q[g][`CRBT_CTL_OVF])
            else $error("auto reload failed");
         baud_noflag_a: assert property (@(posedge clk) disable iff (rst) // [RULE15]
            (wrap[g] && mode[g] == crbt_pkg::CRBT_MODE_BAUD && !swCtlWr[g]
             && !ctl_q[g][`CRBT_CTL_OVF]) |=> !ctl_q[g][`CRBT_CTL_OVF])
            else $error("baud overflow set the flag");
         stop_hold_a: assert property (@(posedge clk) disable iff (rst) // [RULE17]
            (!ctl_q[g][`CRBT_CTL_RUN] && !swCntWr[g]) |=> $stable(count_q[g]))
            else $error("stopped timer moved");
         flag_sticky_a: assert property (@(posedge clk) disable iff (rst) // [RULE19]
            (ctl_q[g][`CRBT_CTL_OVF] && !swCtlWr[g]) |=> ctl_q[g][`CRBT_CTL_OVF])
            else $error("overflow flag cleared by hardware");
         ovf_pulse_a: assert property (@(posedge clk) disable iff (rst) // [RULE21]
            wrap[g] |=> overflowPulse[g] ##1 (!overflowPulse[g] || $past(wrap[g])))
            else $error("overflow pulse missing");
      end
   endgenerate

endmodule
`default_nettype wire

// ===== testbench/crbt_far_end.sv
// far-side model: the event pins and the uart that eats the baud ticks
// assumes the bench sets pinReq after a rising edge; pins idle high
`timescale 1ns/10ps
`default_nettype none
`include "crbt_params.svh"

module crbt_far_end (
   input wire logic clk,
   input wire logic rst,
   input wire logic [`CRBT_NUM_TIMERS-1:0] pinReq,
   output logic [`CRBT_NUM_TIMERS-1:0] eventInputPin,
   input wire logic rxBitTick,
   input wire logic txBaudTick,
   output logic [7:0] rxGap,
   output logic [7:0] txCount
);
   logic [7:0] runCnt; // cycles since the last rx bit tick

   // pin levels are whatever the outside world asks, no glitches added
   assign eventInputPin = pinReq;

   // uart side: measure the bit-clock period, count tx ticks
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         runCnt <= 8'h00;
         rxGap <= 8'h00;
         txCount <= 8'h00;
      end else begin
         // saturating so a stalled clock does not alias to a good period
         if (rxBitTick) begin
            rxGap <= runCnt + 8'h01;
            runCnt <= 8'h00;
         end else if (runCnt != 8'hff) begin
            runCnt <= runCnt + 8'h01;
         end
         if (txBaudTick) begin
            txCount <= txCount + 8'h01;
         end
      end
   end
endmodule
`default_nettype wire

// ===== testbench/tb_top.sv
// self-checking bench for the three capture/reload/baud timers
// assumes design defaults: t0 and t1 at clk/2, t0 falling edge select
`timescale 1ns/10ps
`default_nettype none
`include "crbt_params.svh"

module tb_top;
   logic clk;
   logic rst;
   logic [`CRBT_AW-1:0] addr;
   logic [`CRBT_DW-1:0] wdata;
   logic wrStb;
   logic rdStb;
   logic [`CRBT_DW-1:0] rdata;
   logic [2:0] pinReq;
   logic [2:0] pin;
   logic [2:0] ovfFlag;
   logic [2:0] extFlag;
   logic [2:0] ovfPulse;
   logic rxBaudTick, txBaudTick, rxBitTick, txBitTick;
   logic [7:0] rxGap, txCount;
   int errTotal = 0;
   int numChecks = 0;

   crbt_timers dut (.clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wrStb(wrStb),
      .rdStb(rdStb), .rdata(rdata), .eventInputPin(pin), .overflowFlag(ovfFlag),
      .externalFlag(extFlag), .overflowPulse(ovfPulse), .rxBaudTick(rxBaudTick),
      .txBaudTick(txBaudTick), .rxBitTick(rxBitTick), .txBitTick(txBitTick));

   crbt_far_end farEnd (.clk(clk), .rst(rst), .pinReq(pinReq), .eventInputPin(pin),
      .rxBitTick(rxBitTick), .txBaudTick(txBaudTick), .rxGap(rxGap), .txCount(txCount));

   // 200 MHz clock
   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end

   task automatic end_of_test();
      $display("checks %0d mismatches %0d", numChecks, errTotal);
      if (errTotal == 0 && numChecks > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask

   task automatic chkByte(input logic [7:0] got, input logic [7:0] exp, input string what);
      numChecks++;
      if (got !== exp) begin
         errTotal++;
         $display("BAD %0t %s got %h want %h", $time, what, got, exp);
      end
   endtask

   task automatic chkBit(input logic got, input logic exp, input string what);
      numChecks++;
      if (got !== exp) begin
         errTotal++;
         $display("BAD %0t %s got %b want %b", $time, what, got, exp);
      end
   endtask

   // one-cycle write strobe beside address and data
   task automatic wr(input logic [4:0] a, input logic [7:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wrStb <= 1'b1;
      @(posedge clk);
      wrStb <= 1'b0;
   endtask

   // read data stands only in the cycle after the strobe; sample mid-cycle
   task automatic rd(input logic [4:0] a, output logic [7:0] d);
      @(posedge clk);
      addr <= a;
      rdStb <= 1'b1;
      @(posedge clk);
      rdStb <= 1'b0;
      @(negedge clk);
      d = rdata;
   endtask

   function automatic logic [4:0] ra(input int n, input logic [2:0] off);
      return {n[1:0], off};
   endfunction

   task automatic setPin(input int n, input logic lvl);
      @(posedge clk);
      pinReq[n] <= lvl;
      repeat (10) @(posedge clk);
   endtask

   task automatic test_reset();
      logic [7:0] d;
      rd(ra(0, `CRBT_OFF_CTL), d);
      chkByte(d, `CRBT_CTL_RST, "ctl reset");
      rd(`CRBT_ADDR_SYSCFG, d);
      chkByte(d, `CRBT_SYSCFG_RST, "edge default");
      wr(5'h1f, 8'h5a);
      rd(5'h1f, d);
      chkByte(d, 8'h00, "unmapped");
      $display("test reset done");
   endtask

   task automatic test_reload();
      logic [7:0] d;
      int i;
      logic [7:0] e;
      wr(ra(0, `CRBT_OFF_HOLD_LO), 8'hf0);
      wr(ra(0, `CRBT_OFF_HOLD_HI), 8'hff);
      wr(ra(0, `CRBT_OFF_CNT_LO), 8'hf0);
      wr(ra(0, `CRBT_OFF_CNT_HI), 8'hff);
      wr(ra(0, `CRBT_OFF_CTL), 8'h04);
      // sixteen ticks at clk/2 to wrap; bound well above that
      for (i = 0; i < 200 && ovfPulse[0] !== 1'b1; i++) @(negedge clk);
      if (i == 200) begin
         errTotal++;
         $display("BAD %0t no overflow pulse", $time);
         end_of_test();
      end
      chkBit(ovfFlag[0], 1'b1, "ovf flag");
      rd(ra(0, `CRBT_OFF_CNT_HI), d);
      chkByte(d, 8'hff, "reloaded high");
      wr(ra(0, `CRBT_OFF_CTL), 8'h00);
      @(negedge clk);
      chkBit(ovfFlag[0], 1'b0, "flag cleared");
      rd(ra(0, `CRBT_OFF_CNT_LO), d);
      repeat (20) @(posedge clk);
      rd(ra(0, `CRBT_OFF_CNT_LO), e);
      chkByte(e, d, "stopped count");
      $display("test reload done");
   endtask

   task automatic test_capture();
      logic [7:0] d;
      wr(`CRBT_ADDR_SYSCFG, 8'h0a);
      wr(ra(1, `CRBT_OFF_CNT_LO), 8'h34);
      wr(ra(1, `CRBT_OFF_CNT_HI), 8'h12);
      wr(ra(1, `CRBT_OFF_CTL), 8'h0d);
      setPin(1, 1'b0);
      chkBit(extFlag[1], 1'b1, "capture flag");
      rd(ra(1, `CRBT_OFF_HOLD_HI), d);
      chkByte(d, 8'h12, "captured high");
      rd(ra(1, `CRBT_OFF_HOLD_LO), d);
      // clk/32 lets at most one tick land between start and capture
      chkBit(d == 8'h34 || d == 8'h35, 1'b1, "captured low");
      wr(ra(1, `CRBT_OFF_CTL), 8'h0d);
      setPin(1, 1'b1);
      chkBit(extFlag[1], 1'b0, "rise ignored");
      // pin-fed counter: two falling edges, no trigger
      // switch to the pin first, so no /32 tick lands after the count write
      wr(ra(1, `CRBT_OFF_CTL), 8'h06);
      wr(ra(1, `CRBT_OFF_CNT_LO), 8'h00);
      setPin(1, 1'b0);
      setPin(1, 1'b1);
      setPin(1, 1'b0);
      setPin(1, 1'b1);
      rd(ra(1, `CRBT_OFF_CNT_LO), d);
      chkByte(d, 8'h02, "event count");
      wr(ra(1, `CRBT_OFF_CTL), 8'h00);
      $display("test capture done");
   endtask

   task automatic test_edges();
      logic [1:0] code;
      for (int c = 0; c < 4; c++) begin
         code = c[1:0];
         wr(`CRBT_ADDR_SYSCFG, {4'h0, code, 2'b00});
         wr(ra(0, `CRBT_OFF_CTL), 8'h0d);
         setPin(0, 1'b0);
         chkBit(extFlag[0], code[1], "fall detect");
         wr(ra(0, `CRBT_OFF_CTL), 8'h0d);
         setPin(0, 1'b1);
         chkBit(extFlag[0], code[0], "rise detect");
      end
      wr(ra(0, `CRBT_OFF_CTL), 8'h00);
      $display("test edges done");
   endtask

   task automatic test_baud();
      logic [7:0] d;
      wr(ra(2, `CRBT_OFF_HOLD_LO), 8'hfe);
      wr(ra(2, `CRBT_OFF_HOLD_HI), 8'hff);
      wr(ra(2, `CRBT_OFF_CNT_LO), 8'hfe);
      wr(ra(2, `CRBT_OFF_CNT_HI), 8'hff);
      wr(ra(2, `CRBT_OFF_CTL), 8'h25);
      repeat (200) @(posedge clk);
      @(negedge clk);
      // clk/2 rate, 2 ticks per overflow, 16 overflows per bit
      chkByte(rxGap, 8'h40, "bit period");
      chkBit(ovfFlag[2], 1'b0, "no ovf flag");
      chkByte(txCount, 8'h00, "tx idle");
      rd(ra(2, `CRBT_OFF_CNT_HI), d);
      chkByte(d, 8'hff, "baud reload");
      wr(ra(2, `CRBT_OFF_CTL), 8'h2c);
      setPin(2, 1'b0);
      chkBit(extFlag[2], 1'b1, "baud trigger");
      wr(ra(2, `CRBT_OFF_CTL), 8'h00);
      $display("test baud done");
   endtask

   // cycles between two pulses of a tx tick (sel 0 baud, 1 bit), bounded wait
   task automatic tickGap(input int sel, output int n);
      int k;
      n = 0;
      for (k = 0; k < 600; k++) begin
         @(negedge clk);
         if ((sel == 0) ? txBaudTick : txBitTick) begin
            if (n > 0) break;
            n = 1;
         end else if (n > 0) begin
            n++;
         end
      end
      if (k == 600) begin
         errTotal++;
         $display("BAD %0t tick gap timed out", $time);
         end_of_test();
      end
   endtask

   // timer 2 feeding tx at peripheral /4, hold all ones: one overflow per tick
   task automatic test_txbaud();
      int n;
      wr(`CRBT_ADDR_SYSCFG, 8'h10);
      wr(ra(2, `CRBT_OFF_HOLD_LO), 8'hff);
      wr(ra(2, `CRBT_OFF_HOLD_HI), 8'hff);
      wr(ra(2, `CRBT_OFF_CNT_LO), 8'hff);
      wr(ra(2, `CRBT_OFF_CNT_HI), 8'hff);
      wr(ra(2, `CRBT_OFF_CTL), 8'h14);
      tickGap(0, n);
      // peripheral clock is clk/2, so its /4 gives one tick per 8 cycles
      chkByte(n[7:0], 8'h08, "tx tick period");
      tickGap(1, n);
      chkByte(n[7:0], 8'h80, "tx bit period");
      chkBit(rxBaudTick, 1'b0, "rx quiet");
      chkBit(ovfFlag[2], 1'b0, "tx no ovf flag");
      wr(ra(2, `CRBT_OFF_CTL), 8'h00);
      $display("test txbaud done");
   endtask

   initial begin
      rst = 1'b1;
      addr = '0;
      wdata = '0;
      wrStb = 1'b0;
      rdStb = 1'b0;
      pinReq = 3'b111;
      repeat (3) @(posedge clk);
      rst <= 1'b0;
      repeat (8) @(posedge clk);
      test_reset();
      test_reload();
      test_capture();
      test_edges();
      test_baud();
      test_txbaud();
      end_of_test();
   end
endmodule
`default_nettype wire
